// ==== hdl/fdc_regs.vh ====
`ifndef FDC_REGS_VH
`define FDC_REGS_VH

// ====================
// Channel count and reset values
`define FDC_NCH 4
`define FDC_RST_ADDR 32'h0000_0000
`define FDC_RST_CNT 16'h0000

// ====================
// Access size codes, shared by source and destination
`define FDC_SZ_BYTE 2'h0
`define FDC_SZ_WORD 2'h1
`define FDC_SZ_LONG 2'h2
`define FDC_SZ_LINE 2'h3

// Bytes moved by each size code
`define FDC_BYTES_BYTE 5'h01
`define FDC_BYTES_WORD 5'h02
`define FDC_BYTES_LONG 5'h04
`define FDC_BYTES_LINE 5'h10

// Last beat index of a line access (four longword beats)
`define FDC_LINE_LAST_BEAT 2'h3

// ====================
// Holding buffer: 16 entries of one byte
`define FDC_FIFO_WIDTH 8
`define FDC_FIFO_DEPTH 16
`define FDC_FIFO_AW 4

// ====================
// Idle cycles a channel sits out after each operand,
// indexed by its two bandwidth bits
`define FDC_GAP_0 8'h00
`define FDC_GAP_1 8'h04
`define FDC_GAP_2 8'h10
`define FDC_GAP_3 8'h40

// ====================
// Low address bits covered by the on-chip register window
`define FDC_ONCHIP_BITS 10

`endif

// ==== hdl/fdc_dma.v ====
`timescale 1ns/1ns
`include "fdc_regs.vh"

// ====================
// Byte holding buffer
module fdc_fifo #(
  parameter WIDTH = `FDC_FIFO_WIDTH,
  parameter DEPTH = `FDC_FIFO_DEPTH,
  parameter AW = `FDC_FIFO_AW
)(
  input wire clk_sys,
  input wire rst_sync_n,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_reg;
  reg [AW-1:0] rd_ptr_reg;
  reg [AW:0] fill_reg;
  wire push;
  wire pop;

  // Full and empty come straight from the fill count
  assign in_ready = (fill_reg != DEPTH[AW:0]);
  assign out_valid = (fill_reg != {(AW+1){1'b0}});
  assign out_data = mem[rd_ptr_reg];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Storage has no reset; only the pointers and the fill count need one
  always @(posedge clk_sys)
  begin
    if (push)
      mem[wr_ptr_reg] <= in_data;
  end

  // Pointer and fill bookkeeping
  always @(posedge clk_sys or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      fill_reg <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop)
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      if (push & ~pop)
        fill_reg <= fill_reg + 1'b1;
      else if (pop & ~push)
        fill_reg <= fill_reg - 1'b1;
    end
  end
endmodule

// ====================
// Four-channel transfer engine
// How it works
// R1: Four identical independent channels.
// R2: Operands of 1, 2, 4 or 16 bytes via a 16-byte buffer.
// R3: Separate source and destination widths, repacked.
// R4: Arbitration only between operands, lowest channel first.
// R5: A request line pulled low asks for an operand.
// R6: Unused request lines are held high.
// R7: Channels 0, 1 from pins; 2, 3 from serial port interrupts.
// R8: Each request pin is a request or a parallel port bit.
// R9: Start bit or external request starts a channel.
// R10: Continuous or cycle-steal mode, with a programmable idle gap.
// R11: Single-address: engine drives address and control only.
// R12: Single-address needs an external request.
// R13: Dual-address reads the source, then writes the destination.
// R14: 32-bit addresses and data.
// R15: Single-address to the on-chip window is refused.
// R16: A running channel takes requests and drives each access.
// R17: Busy, done and error per channel.
// R18: Count drops by access size as a write or single access completes.
// R19: Single-address uses the source address only.
// R20: Software loads are never blocked.
// R21: Count zero stops the channel and sets done.
module fdc_dma #(
  parameter CNT_W = 16,
  parameter GAP_W = 8
)(
  input wire clk_sys,
  input wire rst_n,
  input wire [127:0] cfg_src_addr,
  input wire [127:0] cfg_dst_addr,
  input wire [4*CNT_W-1:0] cfg_byte_count,
  input wire [3:0] cfg_load,
  input wire [3:0] cfg_start,
  input wire [3:0] cfg_clear,
  input wire [3:0] cfg_single,
  input wire [3:0] cfg_single_write,
  input wire [3:0] cfg_ext_req,
  input wire [3:0] cfg_cycle_steal,
  input wire [3:0] cfg_src_inc,
  input wire [3:0] cfg_dst_inc,
  input wire [7:0] cfg_src_size,
  input wire [7:0] cfg_dst_size,
  input wire [7:0] cfg_bandwidth,
  input wire [31:0] module_base_pointer,
  input wire [1:0] pin_assignment_reg,
  input wire [1:0] dma_request_n,
  input wire [1:0] uart_irq_n,
  output wire [1:0] parallel_port_bits,
  output wire bus_valid,
  output wire bus_write,
  output wire bus_single,
  output wire bus_last,
  output wire [1:0] bus_size,
  output wire [1:0] bus_channel,
  output wire [31:0] bus_addr,
  output wire [31:0] bus_wdata,
  input wire bus_ready,
  input wire [31:0] bus_rdata,
  output wire [3:0] chan_busy,
  output wire [3:0] chan_done,
  output wire [3:0] chan_error,
  output wire [4*CNT_W-1:0] chan_remaining
);
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_ISSUE = 3'h1;
  localparam [2:0] ST_READ = 3'h2;
  localparam [2:0] ST_PUSH = 3'h3;
  localparam [2:0] ST_POP = 3'h4;
  localparam [2:0] ST_WRITE = 3'h5;
  localparam [2:0] ST_SINGLE = 3'h6;
  localparam [2:0] ST_END = 3'h7;

  // ====================
  // Helpers
  function [4:0] fdc_bytes;
    input [1:0] sz;
    begin
      case (sz)
        `FDC_SZ_BYTE: fdc_bytes = `FDC_BYTES_BYTE;
        `FDC_SZ_WORD: fdc_bytes = `FDC_BYTES_WORD;
        `FDC_SZ_LONG: fdc_bytes = `FDC_BYTES_LONG;
        default: fdc_bytes = `FDC_BYTES_LINE;
      endcase
    end
  endfunction

  // Bytes on the 32-bit data path per beat
  function [2:0] fdc_beat_bytes;
    input [1:0] sz;
    begin
      case (sz)
        `FDC_SZ_BYTE: fdc_beat_bytes = 3'h1;
        `FDC_SZ_WORD: fdc_beat_bytes = 3'h2;
        default: fdc_beat_bytes = 3'h4;
      endcase
    end
  endfunction

  function [GAP_W-1:0] fdc_gap;
    input [1:0] bw;
    begin
      case (bw)
        2'h0: fdc_gap = `FDC_GAP_0;
        2'h1: fdc_gap = `FDC_GAP_1;
        2'h2: fdc_gap = `FDC_GAP_2;
        default: fdc_gap = `FDC_GAP_3;
      endcase
    end
  endfunction

  // Saturating count decrement, never wraps below zero
  function [CNT_W-1:0] fdc_dec;
    input [CNT_W-1:0] cnt;
    input [4:0] b;
    begin
      if (cnt > {{(CNT_W-5){1'b0}}, b})
        fdc_dec = cnt - {{(CNT_W-5){1'b0}}, b};
      else
        fdc_dec = {CNT_W{1'b0}};
    end
  endfunction

  // ====================
  // Reset release
  reg rst_s1_reg;
  reg rst_sync_n_reg;

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_s1_reg <= 1'b0;
      rst_sync_n_reg <= 1'b0;
    end
    else
    begin
      rst_s1_reg <= 1'b1;
      rst_sync_n_reg <= rst_s1_reg;
    end
  end

  // ====================
  // Request pins
  reg [1:0] pin_s1_reg;
  reg [1:0] pin_s2_reg;
  reg [1:0] pin_s3_reg;
  reg [1:0] pin_filt_reg;
  reg [1:0] pport_reg;
  wire [3:0] req_act;

  // Three stages; a level counts once stages two and three agree
  always @(posedge clk_sys or negedge rst_sync_n_reg)
  begin
    if (!rst_sync_n_reg)
    begin
      pin_s1_reg <= 2'h3;
      pin_s2_reg <= 2'h3;
      pin_s3_reg <= 2'h3;
      pin_filt_reg <= 2'h3; // R6
      pport_reg <= 2'h3;
    end
    else
    begin
      pin_s1_reg <= dma_request_n;
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
      pin_filt_reg <= (pin_s2_reg & pin_s3_reg) |
        (pin_filt_reg & (pin_s2_reg | pin_s3_reg));
      pport_reg <= pin_filt_reg | pin_assignment_reg; // R8
    end
  end

  // Serial port interrupts are on this clock and need no sync
  assign req_act = {~uart_irq_n, ~pin_filt_reg & pin_assignment_reg}; // R5 R7 R8
  assign parallel_port_bits = pport_reg;

  // ====================
  // Channel state
  reg [31:0] src_reg [0:3];
  reg [31:0] dst_reg [0:3];
  reg [CNT_W-1:0] cnt_reg [0:3];
  reg [GAP_W-1:0] gap_reg [0:3];
  reg [3:0] act_reg;
  reg [3:0] done_reg;
  reg [3:0] err_reg;
  reg [3:0] seen_reg;

  // Engine state
  reg [2:0] st_reg;
  reg [1:0] cur_reg;
  reg [4:0] rd_left_reg;
  reg [4:0] wr_left_reg;
  reg [1:0] beat_reg;
  reg [2:0] nb_reg;
  reg [1:0] pack_reg;
  reg [31:0] sh_reg;
  reg bv_reg;
  reg bw_reg;
  reg bs_reg;
  reg bl_reg;
  reg [1:0] bsz_reg;
  reg [31:0] ba_reg;
  reg [31:0] bd_reg;

  // ====================
  // Eligibility and fixed-priority choice
  reg [3:0] elig;
  reg [1:0] pick;
  reg pick_any;
  integer k;

  always @*
  begin
    pick = 2'h0;
    pick_any = 1'b0;
    for (k = 3; k >= 0; k = k - 1)
    begin
      elig[k] = act_reg[k] & (gap_reg[k] == {GAP_W{1'b0}}) &
        (~cfg_ext_req[k] | req_act[k] |
        (seen_reg[k] & ~cfg_cycle_steal[k])); // R9 R10
      if (elig[k])
      begin
        pick = k[1:0]; // R4
        pick_any = 1'b1;
      end
    end
  end

  // ====================
  // Fields of the channel being served
  wire [1:0] c_ssz = cfg_src_size[{cur_reg, 1'b0} +: 2];
  wire [1:0] c_dsz = cfg_dst_size[{cur_reg, 1'b0} +: 2];
  wire [1:0] c_bw = cfg_bandwidth[{cur_reg, 1'b0} +: 2];
  wire [4:0] c_sb = fdc_bytes(c_ssz);
  wire [4:0] c_db = fdc_bytes(c_dsz);
  wire [31:0] c_src = src_reg[cur_reg];
  wire [31:0] c_dst = dst_reg[cur_reg];
  wire [31:0] c_src_nx = c_src +
    (cfg_src_inc[cur_reg] ? {27'h000_0000, c_sb} : 32'h0000_0000);
  wire [31:0] c_dst_nx = c_dst +
    (cfg_dst_inc[cur_reg] ? {27'h000_0000, c_db} : 32'h0000_0000);
  wire [1:0] beat_nx = beat_reg + 2'h1;
  wire [31:0] beat_off = {28'h000_0000, beat_nx, 2'h0};
  wire src_last = (c_ssz != `FDC_SZ_LINE) |
    (beat_reg == `FDC_LINE_LAST_BEAT);
  wire dst_last = (c_dsz != `FDC_SZ_LINE) |
    (beat_reg == `FDC_LINE_LAST_BEAT);

  // Buffer hookup; a full buffer stalls the unpack state
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [7:0] fifo_out_data;

  fdc_fifo #(
    .WIDTH(`FDC_FIFO_WIDTH),
    .DEPTH(`FDC_FIFO_DEPTH),
    .AW(`FDC_FIFO_AW)
  ) u_fifo (
    .clk_sys(clk_sys),
    .rst_sync_n(rst_sync_n_reg),
    .in_valid(st_reg == ST_PUSH),
    .in_ready(fifo_in_ready),
    .in_data(sh_reg[7:0]),
    .out_valid(fifo_out_valid),
    .out_ready(st_reg == ST_POP),
    .out_data(fifo_out_data)
  ); // R2

  // ====================
  // Channel registers and the engine share one process so
  // that a software load can win over an engine update
  integer i;

  always @(posedge clk_sys or negedge rst_sync_n_reg)
  begin
    if (!rst_sync_n_reg)
    begin
      for (i = 0; i < `FDC_NCH; i = i + 1)
      begin
        src_reg[i] <= `FDC_RST_ADDR;
        dst_reg[i] <= `FDC_RST_ADDR;
        cnt_reg[i] <= `FDC_RST_CNT;
        gap_reg[i] <= {GAP_W{1'b0}};
      end
      act_reg <= 4'h0;
      done_reg <= 4'h0;
      err_reg <= 4'h0;
      seen_reg <= 4'h0;
      st_reg <= ST_IDLE;
      cur_reg <= 2'h0;
      rd_left_reg <= 5'h00;
      wr_left_reg <= 5'h00;
      beat_reg <= 2'h0;
      nb_reg <= 3'h0;
      pack_reg <= 2'h0;
      sh_reg <= 32'h0000_0000;
      bv_reg <= 1'b0;
      bw_reg <= 1'b0;
      bs_reg <= 1'b0;
      bl_reg <= 1'b0;
      bsz_reg <= 2'h0;
      ba_reg <= 32'h0000_0000;
      bd_reg <= 32'h0000_0000;
    end
    else
    begin
      // Gap countdown and continuous-mode request latch
      for (i = 0; i < `FDC_NCH; i = i + 1)
      begin
        if (gap_reg[i] != {GAP_W{1'b0}})
          gap_reg[i] <= gap_reg[i] - 1'b1;
        if (act_reg[i] & cfg_ext_req[i] & req_act[i])
          seen_reg[i] <= 1'b1;
        if (cfg_clear[i])
        begin
          done_reg[i] <= 1'b0;
          err_reg[i] <= 1'b0;
        end
      end

      // Transfer sequencer, one operand per pass
      case (st_reg)
        ST_IDLE:
        begin
          if (pick_any)
          begin
            cur_reg <= pick;
            st_reg <= ST_ISSUE;
          end
        end
        ST_ISSUE:
        begin
          rd_left_reg <= (c_sb > c_db) ? c_sb : c_db; // R3
          wr_left_reg <= (c_sb > c_db) ? c_sb : c_db;
          beat_reg <= 2'h0;
          bv_reg <= 1'b1;
          bsz_reg <= c_ssz;
          ba_reg <= c_src; // R19
          bl_reg <= (c_ssz != `FDC_SZ_LINE);
          bs_reg <= cfg_single[cur_reg]; // R11
          bw_reg <= cfg_single[cur_reg] & cfg_single_write[cur_reg];
          st_reg <= cfg_single[cur_reg] ? ST_SINGLE : ST_READ;
        end
        ST_SINGLE:
        begin
          if (bus_ready)
          begin
            if (beat_reg == 2'h0)
              cnt_reg[cur_reg] <= fdc_dec(cnt_reg[cur_reg], c_sb); // R18
            if (src_last)
            begin
              bv_reg <= 1'b0;
              bs_reg <= 1'b0;
              src_reg[cur_reg] <= c_src_nx;
              st_reg <= ST_END;
            end
            else
            begin
              beat_reg <= beat_nx;
              ba_reg <= c_src + beat_off;
              bl_reg <= (beat_nx == `FDC_LINE_LAST_BEAT);
            end
          end
        end
        ST_READ:
        begin
          if (bus_ready)
          begin
            bv_reg <= 1'b0;
            sh_reg <= bus_rdata; // R14
            nb_reg <= fdc_beat_bytes(c_ssz);
            st_reg <= ST_PUSH;
          end
        end
        ST_PUSH:
        begin
          // Unpack one byte per cycle, low lane first
          if (fifo_in_ready)
          begin
            sh_reg <= {8'h00, sh_reg[31:8]};
            nb_reg <= nb_reg - 3'h1;
            rd_left_reg <= rd_left_reg - 5'h01;
            if (nb_reg == 3'h1)
            begin
              if (!src_last)
              begin
                beat_reg <= beat_nx;
                bv_reg <= 1'b1;
                ba_reg <= c_src + beat_off;
                bl_reg <= (beat_nx == `FDC_LINE_LAST_BEAT);
                st_reg <= ST_READ;
              end
              else
              begin
                beat_reg <= 2'h0;
                src_reg[cur_reg] <= c_src_nx;
                pack_reg <= 2'h0;
                if (rd_left_reg == 5'h01)
                  st_reg <= ST_POP; // R13
                else
                begin
                  bv_reg <= 1'b1;
                  ba_reg <= c_src_nx;
                  bl_reg <= 1'b1;
                  st_reg <= ST_READ;
                end
              end
            end
          end
        end
        ST_POP:
        begin
          // Repack into destination lanes
          if (fifo_out_valid)
          begin
            bd_reg[{pack_reg, 3'h0} +: 8] <= fifo_out_data; // R3
            pack_reg <= pack_reg + 2'h1;
            wr_left_reg <= wr_left_reg - 5'h01;
            if ({1'b0, pack_reg} == fdc_beat_bytes(c_dsz) - 3'h1)
            begin
              pack_reg <= 2'h0;
              bv_reg <= 1'b1;
              bw_reg <= 1'b1;
              bsz_reg <= c_dsz;
              ba_reg <= c_dst + {28'h000_0000, beat_reg, 2'h0};
              bl_reg <= dst_last;
              st_reg <= ST_WRITE; // R13
            end
          end
        end
        ST_WRITE:
        begin
          if (bus_ready)
          begin
            if (beat_reg == 2'h0)
              cnt_reg[cur_reg] <= fdc_dec(cnt_reg[cur_reg], c_db); // R18
            bv_reg <= 1'b0;
            bw_reg <= 1'b0;
            if (!dst_last)
            begin
              beat_reg <= beat_nx;
              st_reg <= ST_POP;
            end
            else
            begin
              beat_reg <= 2'h0;
              dst_reg[cur_reg] <= c_dst_nx;
              st_reg <= (wr_left_reg == 5'h00) ? ST_END : ST_POP;
            end
          end
        end
        ST_END:
        begin
          // Operand boundary: only here may another channel win
          gap_reg[cur_reg] <= fdc_gap(c_bw); // R10 R4
          if (cnt_reg[cur_reg] == {CNT_W{1'b0}})
          begin
            act_reg[cur_reg] <= 1'b0; // R21
            done_reg[cur_reg] <= 1'b1; // R17
          end
          st_reg <= ST_IDLE;
        end
        default:
          st_reg <= ST_IDLE;
      endcase

      // Software loads and starts, taken at any time
      for (i = 0; i < `FDC_NCH; i = i + 1)
      begin
        if (cfg_load[i])
        begin
          src_reg[i] <= cfg_src_addr[32*i +: 32]; // R20
          dst_reg[i] <= cfg_dst_addr[32*i +: 32];
          cnt_reg[i] <= cfg_byte_count[CNT_W*i +: CNT_W];
        end
        if (cfg_start[i])
        begin
          seen_reg[i] <= 1'b0;
          if (cfg_single[i] & (~cfg_ext_req[i] |
            (src_reg[i][31:`FDC_ONCHIP_BITS] ==
            module_base_pointer[31:`FDC_ONCHIP_BITS])))
            err_reg[i] <= 1'b1; // R12 R15 R17
          else if (cnt_reg[i] == {CNT_W{1'b0}})
            done_reg[i] <= 1'b1; // R21
          else
          begin
            act_reg[i] <= 1'b1; // R9 R16
            done_reg[i] <= 1'b0;
          end
        end
      end
    end
  end

  // ====================
  // Outputs, all from flops
  assign bus_valid = bv_reg;
  assign bus_write = bw_reg;
  assign bus_single = bs_reg;
  assign bus_last = bl_reg;
  assign bus_size = bsz_reg;
  assign bus_channel = cur_reg;
  assign bus_addr = ba_reg;
  assign bus_wdata = bd_reg;
  assign chan_busy = act_reg; // R1
  assign chan_done = done_reg;
  assign chan_error = err_reg;
  assign chan_remaining = {cnt_reg[3], cnt_reg[2], cnt_reg[1],
    cnt_reg[0]};
endmodule

// ==== test/fdc_dma_monitor.sv ====
`timescale 1ns/1ns
// ====================
// Port-level checker
module fdc_dma_mon #(
  parameter CNT_W = 16
)(
  input wire clk_sys,
  input wire rst_n,
  input wire [3:0] cfg_start,
  input wire [3:0] cfg_single,
  input wire [3:0] cfg_ext_req,
  input wire [7:0] cfg_src_size,
  input wire [7:0] cfg_dst_size,
  input wire [31:0] module_base_pointer,
  input wire [1:0] pin_assignment_reg,
  input wire [1:0] parallel_port_bits,
  input wire bus_valid,
  input wire bus_write,
  input wire bus_single,
  input wire bus_last,
  input wire [1:0] bus_size,
  input wire [1:0] bus_channel,
  input wire [31:0] bus_addr,
  input wire bus_ready,
  input wire [3:0] chan_busy,
  input wire [3:0] chan_done,
  input wire [3:0] chan_error,
  input wire [4*CNT_W-1:0] chan_remaining
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  // ====================
  // Bus access shape
  a_req_hold: assert property (bus_valid && !bus_ready |=> bus_valid &&
    $stable(bus_addr) && $stable(bus_channel) && $stable(bus_write))
    else $error("request changed");
  a_beat_drop: assert property (bus_valid && bus_ready && bus_last
    |=> !bus_valid)
    else $error("valid after last");
  // Size per side, from the owning channel
  a_src_size: assert property (bus_valid && !bus_write && !bus_single
    |-> bus_size == cfg_src_size[2*bus_channel +: 2])
    else $error("read size");
  a_dst_size: assert property (bus_valid && bus_write && !bus_single
    |-> bus_size == cfg_dst_size[2*bus_channel +: 2])
    else $error("write size");
  // Single accesses avoid the on-chip window
  a_single_win: assert property (bus_valid && bus_single
    |-> cfg_single[bus_channel] &&
    bus_addr[31:10] != module_base_pointer[31:10])
    else $error("single to window");

  // ====================
  // Channel start and completion
  a_single_ext: assert property (cfg_start[3] && cfg_single[3] &&
    !cfg_ext_req[3] && !chan_busy[3] |=> chan_error[3] && !chan_busy[3])
    else $error("single start taken");
  a_start_ans: assert property (cfg_start[1] && !chan_busy[1] &&
    !cfg_single[1] |=> chan_busy[1] || chan_done[1])
    else $error("start ignored");
  a_done_zero: assert property ($rose(chan_done[0]) |->
    !chan_busy[0] && chan_remaining[CNT_W-1:0] == 0)
    else $error("done with bytes left");
  // Registered mux: select checked one cycle back
  a_pin_mux: assert property (pin_assignment_reg[0] &&
    $past(pin_assignment_reg[0]) |-> parallel_port_bits[0])
    else $error("pin leaks to port");

  c_single: cover property (bus_valid && bus_ready && bus_single);
  c_line: cover property (bus_valid && bus_ready && bus_size == 2'h3);
  c_refuse: cover property ($rose(chan_error[3]));
endmodule

bind fdc_dma fdc_dma_mon #(.CNT_W(CNT_W)) mon_u (.clk_sys, .rst_n,
  .cfg_start, .cfg_single, .cfg_ext_req, .cfg_src_size, .cfg_dst_size,
  .module_base_pointer, .pin_assignment_reg, .parallel_port_bits,
  .bus_valid, .bus_write, .bus_single, .bus_last, .bus_size, .bus_channel,
  .bus_addr, .bus_ready, .chan_busy, .chan_done, .chan_error,
  .chan_remaining);

// ==== test/fdc_mem_model.sv ====
`timescale 1ns/1ns
// ====================
// Memory and peripheral on the system bus
module fdc_mem_model (
  input wire clk_sys,
  input wire [3:0] wait_cyc,
  input wire bus_valid,
  input wire bus_write,
  input wire [31:0] bus_addr,
  input wire [31:0] bus_wdata,
  output reg bus_ready,
  output reg [31:0] bus_rdata,
  output reg [31:0] wr_addr,
  output reg [31:0] wr_data,
  output reg [15:0] wr_count
);
  reg [3:0] wait_reg;
  wire [7:0] a = bus_addr[7:0];

  initial
  begin
    bus_ready = 1'b0;
    bus_rdata = 32'h0000_0000;
    wr_addr = 32'h0000_0000;
    wr_data = 32'h0000_0000;
    wr_count = 16'h0000;
    wait_reg = 4'h0;
  end

  // Byte at address a reads as a; idle data toggles every cycle
  // so a stale lane can never pass for a fresh one
  always @(posedge clk_sys)
  begin
    bus_ready <= 1'b0;
    bus_rdata <= ~bus_rdata;
    if (bus_valid && !bus_ready && wait_reg >= wait_cyc)
    begin
      bus_ready <= 1'b1;
      bus_rdata <= {a + 8'h03, a + 8'h02, a + 8'h01, a};
      wait_reg <= 4'h0;
    end
    else if (bus_valid && !bus_ready)
      wait_reg <= wait_reg + 4'h1;
    if (bus_valid && bus_ready && bus_write)
    begin
      wr_addr <= bus_addr;
      wr_data <= bus_wdata;
      wr_count <= wr_count + 16'h0001;
    end
  end
endmodule

// ==== test/tb_top.sv ====
`timescale 1ns/1ns
// ====================
// Bench for the four-channel engine
module tb_top;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [127:0] cfg_src_addr = '0;
  logic [127:0] cfg_dst_addr = '0;
  logic [63:0] cfg_byte_count = '0;
  logic [3:0] cfg_load = '0, cfg_start = '0, cfg_clear = '0;
  logic [3:0] cfg_single = '0, cfg_single_write = '0, cfg_ext_req = '0;
  logic [3:0] cfg_cycle_steal = '0, cfg_src_inc = 4'hf, cfg_dst_inc = 4'hf;
  logic [7:0] cfg_src_size = '0, cfg_dst_size = '0, cfg_bandwidth = '0;
  logic [31:0] module_base_pointer = 32'h1000_0000;
  logic [1:0] pin_assignment_reg = 2'h3;
  // Unused request lines idle high
  logic [1:0] dma_request_n = 2'h3;
  logic [1:0] uart_irq_n = 2'h3;
  logic [3:0] wt = 4'h0;
  wire [1:0] parallel_port_bits, bus_size, bus_channel;
  wire bus_valid, bus_write, bus_single, bus_last, bus_ready;
  wire [31:0] bus_addr, bus_wdata, bus_rdata, wr_addr, wr_data;
  wire [15:0] wr_count;
  wire [3:0] chan_busy, chan_done, chan_error;
  wire [63:0] chan_remaining;
  int errors = 0;
  int n_checks = 0;

  fdc_dma dut_u (.clk_sys, .rst_n, .cfg_src_addr, .cfg_dst_addr,
    .cfg_byte_count, .cfg_load, .cfg_start, .cfg_clear, .cfg_single,
    .cfg_single_write, .cfg_ext_req, .cfg_cycle_steal, .cfg_src_inc,
    .cfg_dst_inc, .cfg_src_size, .cfg_dst_size, .cfg_bandwidth,
    .module_base_pointer, .pin_assignment_reg, .dma_request_n, .uart_irq_n,
    .parallel_port_bits, .bus_valid, .bus_write, .bus_single, .bus_last,
    .bus_size, .bus_channel, .bus_addr, .bus_wdata, .bus_ready, .bus_rdata,
    .chan_busy, .chan_done, .chan_error, .chan_remaining);
  fdc_mem_model mem_u (.clk_sys, .wait_cyc(wt), .bus_valid, .bus_write,
    .bus_addr, .bus_wdata, .bus_ready, .bus_rdata, .wr_addr, .wr_data,
    .wr_count);

  always #25 clk_sys = ~clk_sys;

  // ====================
  // Helpers
  task automatic end_sim;
    $display("Checks %0d, errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Inputs move 1 ns after the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic load(input int c, input logic [31:0] s, input logic [31:0] d,
    input logic [15:0] n, input logic [1:0] ss, input logic [1:0] ds);
    cfg_src_addr[32*c +: 32] = s;
    cfg_dst_addr[32*c +: 32] = d;
    cfg_byte_count[16*c +: 16] = n;
    cfg_src_size[2*c +: 2] = ss;
    cfg_dst_size[2*c +: 2] = ds;
    cfg_load[c] = 1'b1;
    tick(1);
    cfg_load[c] = 1'b0;
  endtask
  task automatic start(input logic [3:0] m);
    cfg_start = m;
    tick(1);
    cfg_start = 4'h0;
    tick(1);
  endtask
  task automatic clear(input int c);
    cfg_clear[c] = 1'b1;
    tick(1);
    cfg_clear[c] = 1'b0;
    tick(1);
  endtask
  task automatic wait_end(input int c);
    int k;
    k = 0;
    while (!(chan_done[c] === 1'b1 || chan_error[c] === 1'b1) && k < 3000)
    begin
      tick(1);
      k++;
    end
    check(k < 3000, 1'b1);
  endtask
  // Dual block 0x100 -> 0x200; last beat holds the last source bytes
  task automatic run(input int c, input logic [1:0] ss,
    input logic [1:0] ds, input logic [15:0] n);
    logic [31:0] w, m, a;
    logic [15:0] wc0;
    w = (ds == 2'h3) ? 32'h0000_0004 : (32'h0000_0001 << ds);
    m = (w == 1) ? 32'h0000_00ff : (w == 2) ? 32'h0000_ffff : 32'hffff_ffff;
    a = n - w;
    wc0 = wr_count;
    load(c, 32'h0000_0100, 32'h0000_0200, n, ss, ds);
    start(4'h1 << c);
    wait_end(c);
    check(chan_remaining[16*c +: 16], 16'h0000);
    check(wr_count - wc0, n / w);
    check(wr_addr, 32'h0000_0200 + a);
    check(wr_data & m, {a[7:0] + 8'h03, a[7:0] + 8'h02,
      a[7:0] + 8'h01, a[7:0]} & m);
    clear(c);
  endtask

  // Watchdog: tests need a few thousand cycles
  initial
  begin
    #1000000;
    errors++;
    end_sim();
  end

  // ====================
  // Test sequence
  initial
  begin
    repeat (5) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    tick(3);
    check(chan_busy | chan_done | chan_error, 4'h0);
    check(bus_valid, 1'b0);
    check(parallel_port_bits, 2'h3);
    for (int s = 0; s < 4; s++)
      run(1, s, s, 16'h0020);
    run(2, 2'h0, 2'h2, 16'h0008);
    run(2, 2'h3, 2'h0, 16'h0010);
    // Slow partner, wide reads feeding narrow writes
    wt = 4'h3;
    run(0, 2'h2, 2'h1, 16'h000c);
    wt = 4'h0;
    // Two channels: lowest first, whole block; then 64-cycle gaps
    load(0, 32'h0000_0100, 32'h0000_0200, 16'h0008, 2'h0, 2'h0);
    load(1, 32'h0000_0100, 32'h0000_0300, 16'h0008, 2'h0, 2'h0);
    cfg_bandwidth[3:2] = 2'h3;
    start(4'h3);
    wait_end(0);
    check(chan_remaining[31:16], 16'h0008);
    tick(40);
    check(chan_remaining[31:16], 16'h0007);
    wait_end(1);
    check(chan_remaining[31:16], 16'h0000);
    clear(0);
    clear(1);
    // Refused single starts, then an empty block
    cfg_single[3] = 1'b1;
    load(3, 32'h3000_0000, 32'h0000_0000, 16'h0004, 2'h0, 2'h0);
    start(4'h8);
    check({chan_error[3], chan_busy[3]}, 2'h2);
    clear(3);
    check(chan_error[3], 1'b0);
    cfg_ext_req[3] = 1'b1;
    load(3, 32'h1000_0040, 32'h0000_0000, 16'h0004, 2'h0, 2'h0);
    start(4'h8);
    check({chan_error[3], chan_busy[3]}, 2'h2);
    clear(3);
    cfg_single[3] = 1'b0;
    cfg_ext_req[3] = 1'b0;
    load(3, 32'h0000_0100, 32'h0000_0200, 16'h0000, 2'h0, 2'h0);
    start(4'h8);
    check({chan_done[3], chan_busy[3]}, 2'h2);
    clear(3);
    // Single address on pin request, pin first muxed to the port
    cfg_single[0] = 1'b1;
    cfg_single_write[0] = 1'b1;
    cfg_ext_req[0] = 1'b1;
    cfg_cycle_steal[0] = 1'b1;
    pin_assignment_reg = 2'h2;
    dma_request_n[0] = 1'b0;
    load(0, 32'h3000_0000, 32'h4000_0000, 16'h0002, 2'h0, 2'h0);
    start(4'h1);
    tick(12);
    check(parallel_port_bits[0], 1'b0);
    check(chan_remaining[15:0], 16'h0002);
    pin_assignment_reg = 2'h3;
    wait_end(0);
    dma_request_n[0] = 1'b1;
    check(wr_addr, 32'h3000_0001);
    check(chan_remaining[15:0], 16'h0000);
    clear(0);
    cfg_single[0] = 1'b0;
    cfg_ext_req[0] = 1'b0;
    // Channel 2 on a serial port interrupt pulse: steal, then continuous
    cfg_ext_req[2] = 1'b1;
    cfg_cycle_steal[2] = 1'b1;
    load(2, 32'h0000_0100, 32'h0000_0200, 16'h0002, 2'h0, 2'h0);
    start(4'h4);
    tick(8);
    check(chan_remaining[47:32], 16'h0002);
    uart_irq_n = 2'h2;
    tick(1);
    uart_irq_n = 2'h3;
    tick(30);
    check(chan_remaining[47:32], 16'h0001);
    cfg_cycle_steal[2] = 1'b0;
    wait_end(2);
    check(chan_remaining[47:32], 16'h0000);
    end_sim();
  end
endmodule
